// *** design/acr_pkg.sv ***
package acr_pkg;

	// Register offsets on the plain register port
	localparam logic [2:0] ACR_OFS_CTRL0  = 3'h0;
	localparam logic [2:0] ACR_OFS_CTRL1  = 3'h1;
	localparam logic [2:0] ACR_OFS_RESH   = 3'h2;
	localparam logic [2:0] ACR_OFS_RESL   = 3'h3;
	localparam logic [2:0] ACR_OFS_FLAG   = 3'h4;

	// Control register 0 field positions
	localparam int ACR_BIT_JUSTIFY = 7;
	localparam int ACR_BIT_REF     = 6;
	localparam int ACR_CHS_HI      = 5;
	localparam int ACR_CHS_LO      = 2;
	localparam int ACR_BIT_GO      = 1;
	localparam int ACR_BIT_EN      = 0;
	// Control register 1 field positions
	localparam int ACR_CS_HI       = 6;
	localparam int ACR_CS_LO       = 4;
	// Flag register field position
	localparam int ACR_BIT_DONE    = 0;

	localparam logic [7:0] ACR_RST_CTRL0 = 8'h00;
	localparam logic [2:0] ACR_RST_CS    = 3'h0;

	// Channel codes
	localparam logic [3:0] ACR_CH_EXT_MAX = 4'h3;
	localparam logic [3:0] ACR_CH_DAC     = 4'he;
	localparam logic [3:0] ACR_CH_FVR     = 4'hf;

	// Clock select codes
	localparam logic [2:0] ACR_CS_DIV2  = 3'h0;
	localparam logic [2:0] ACR_CS_DIV4  = 3'h4;
	localparam logic [2:0] ACR_CS_DIV8  = 3'h1;
	localparam logic [2:0] ACR_CS_DIV16 = 3'h5;
	localparam logic [2:0] ACR_CS_DIV32 = 3'h2;
	localparam logic [2:0] ACR_CS_DIV64 = 3'h6;
	localparam logic [2:0] ACR_CS_RC    = 3'h3;
	localparam logic [7:0] ACR_RC_DIV   = 8'd16;

	// Conversion timing in conversion clock periods
	localparam logic [3:0] ACR_STARTUP_PERIODS = 4'd1;
	localparam logic [3:0] ACR_ABORT_PERIODS   = 4'd2;
	localparam logic [3:0] ACR_RESULT_BITS     = 4'd10;

	// Input mux source
	typedef enum logic [1:0] {
		ACR_SRC_EXT  = 2'b00,
		ACR_SRC_DAC  = 2'b01,
		ACR_SRC_FVR  = 2'b10,
		ACR_SRC_NONE = 2'b11
	} acr_src_t;

	// Analog core steering
	typedef struct packed {
		logic       powered;
		logic       ref_ext;
		acr_src_t   source;
		logic [1:0] ext_index;
		logic       sample;
		logic [9:0] trial;
	} acr_analog_t;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} acr_bus_t;

	typedef enum logic [1:0] {
		ACR_ST_IDLE    = 2'b00,
		ACR_ST_STARTUP = 2'b01,
		ACR_ST_CONVERT = 2'b10,
		ACR_ST_ABORT   = 2'b11
	} acr_state_t;

endpackage

// *** design/acr_tick_gen.sv ***
`timescale 1ns/1ps
module acr_tick_gen
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] clock_select,
	input  wire logic       rc_osc,
	// Conversion clock period tick
	output logic            tick
);
	typedef struct packed {
		logic [6:0] count;
		logic       rc_s1;
		logic       rc_s2;
		logic       rc_s3;
		logic [7:0] rc_count;
		logic       tick;
	} acr_tick_state_t;

	acr_tick_state_t s_q;
	acr_tick_state_t s_d;
	logic [6:0]      limit;

	always_comb begin
		case (clock_select)
			ACR_CS_DIV2:  limit = 7'd1;
			ACR_CS_DIV4:  limit = 7'd3;
			ACR_CS_DIV8:  limit = 7'd7;
			ACR_CS_DIV16: limit = 7'd15;
			ACR_CS_DIV32: limit = 7'd31;
			ACR_CS_DIV64: limit = 7'd63;
			default:      limit = 7'd0;
		endcase
	end

	always_comb begin
		s_d       = s_q;
		s_d.tick  = 1'b0;
		s_d.rc_s1 = rc_osc;
		s_d.rc_s2 = s_q.rc_s1;
		s_d.rc_s3 = s_q.rc_s2;
		if (!run) begin
			s_d.count    = 7'd0;
			s_d.rc_count = 8'd0;
		end else if (clock_select == ACR_CS_RC) begin
			if (s_q.rc_s2 && !s_q.rc_s3) begin
				if (s_q.rc_count == ACR_RC_DIV - 8'd1) begin
					s_d.rc_count = 8'd0;
					s_d.tick     = 1'b1;
				end else begin
					s_d.rc_count = s_q.rc_count + 8'd1;
				end
			end
		end else if (s_q.count >= limit) begin
			s_d.count = 7'd0;
			s_d.tick  = 1'b1;
		end else begin
			s_d.count = s_q.count + 7'd1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule

// *** design/acr_core.sv ***
`timescale 1ns/1ps
module acr_core
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                sys_rst,
	// Register port
	input  wire logic [2:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	// Triggers and clock sources
	input  wire logic                special_trigger,
	input  wire logic                rc_osc,
	// Analog core
	input  wire logic                comparator_out,
	output acr_pkg::acr_analog_t     analog,
	// Events
	output logic                     conversion_done_flag,
	output logic                     conversion_done_pulse
);
	typedef struct packed {
		logic       result_justify_select;
		logic       reference_select;
		logic [3:0] channel_select;
		logic       go;
		logic       converter_enable;
		logic [2:0] conversion_clock_select;
		logic [9:0] conversion_result;
		logic [9:0] sar;
		logic [3:0] bit_index;
		logic [3:0] wait_count;
		logic       restart;
		acr_state_t state;
		logic       done_flag;
		logic       done_pulse;
		logic       trig_s1;
		logic       trig_s2;
		logic       trig_s3;
		logic [7:0] rdata;
		acr_analog_t analog;
	} acr_core_state_t;

	acr_core_state_t s_q;
	acr_core_state_t s_d;
	logic            tick;
	logic            trig_edge;
	logic            wr_ctrl0;
	logic            sw_go_set;
	logic            sw_go_clr;
	logic            start;
	logic [9:0]      trial_bit;
	logic [7:0]      rd_mux;

	acr_tick_gen u_tick (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.run          ((s_q.state != ACR_ST_IDLE) && !s_q.restart),
		.clock_select (s_q.conversion_clock_select),
		.rc_osc       (rc_osc),
		.tick         (tick)
	);

	assign trig_edge = s_q.trig_s2 && !s_q.trig_s3;
	assign wr_ctrl0  = reg_wr && (reg_addr == ACR_OFS_CTRL0);
	assign sw_go_set = wr_ctrl0 && reg_wdata[ACR_BIT_GO];
	assign sw_go_clr = wr_ctrl0 && !reg_wdata[ACR_BIT_GO];
	assign trial_bit = 10'h200 >> s_q.bit_index;

	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == ACR_OFS_CTRL0) begin
			rd_mux = {s_q.result_justify_select, s_q.reference_select, s_q.channel_select,
				s_q.go, s_q.converter_enable};
		end else if (reg_addr == ACR_OFS_CTRL1) begin
			rd_mux = {1'b0, s_q.conversion_clock_select, 4'h0};
		end else if (reg_addr == ACR_OFS_RESH) begin
			rd_mux = s_q.result_justify_select ? {6'h00, s_q.conversion_result[9:8]}
				: s_q.conversion_result[9:2];
		end else if (reg_addr == ACR_OFS_RESL) begin
			rd_mux = s_q.result_justify_select ? s_q.conversion_result[7:0]
				: {s_q.conversion_result[1:0], 6'h00};
		end else if (reg_addr == ACR_OFS_FLAG) begin
			rd_mux = {7'h00, s_q.done_flag};
		end
	end

	always_comb begin
		s_d            = s_q;
		s_d.done_pulse = 1'b0;
		s_d.restart    = 1'b0;
		s_d.trig_s1    = special_trigger;
		s_d.trig_s2    = s_q.trig_s1;
		s_d.trig_s3    = s_q.trig_s2;
		s_d.rdata      = reg_rd ? rd_mux : 8'h00;
		start          = 1'b0;

		if (wr_ctrl0) begin
			s_d.result_justify_select = reg_wdata[ACR_BIT_JUSTIFY];
			s_d.reference_select      = reg_wdata[ACR_BIT_REF];
			s_d.channel_select        = reg_wdata[ACR_CHS_HI:ACR_CHS_LO];
			s_d.converter_enable      = reg_wdata[ACR_BIT_EN];
		end
		if (reg_wr && reg_addr == ACR_OFS_CTRL1) begin
			s_d.conversion_clock_select = reg_wdata[ACR_CS_HI:ACR_CS_LO];
		end
		if (reg_wr && reg_addr == ACR_OFS_FLAG && !reg_wdata[ACR_BIT_DONE]) begin
			s_d.done_flag = 1'b0;
		end

		case (s_q.state)
			ACR_ST_IDLE: begin
				if (s_q.converter_enable && (sw_go_set || trig_edge)) begin
					start = 1'b1;
				end
			end
			ACR_ST_STARTUP, ACR_ST_CONVERT: begin
				if (sw_go_clr || !s_d.converter_enable) begin
					s_d.go         = 1'b0;
					s_d.state      = ACR_ST_ABORT;
					s_d.restart    = 1'b1;
					s_d.wait_count = 4'd0;
				end else if (tick && s_q.state == ACR_ST_STARTUP) begin
					if (s_q.wait_count == ACR_STARTUP_PERIODS - 4'd1) begin
						s_d.state     = ACR_ST_CONVERT;
						s_d.bit_index = 4'd0;
						s_d.sar       = 10'h000;
					end else begin
						s_d.wait_count = s_q.wait_count + 4'd1;
					end
				end else if (tick) begin
					if (comparator_out) begin
						s_d.sar = s_q.sar | trial_bit;
					end
					s_d.bit_index = s_q.bit_index + 4'd1;
					if (s_q.bit_index == ACR_RESULT_BITS - 4'd1) begin
						s_d.go                = 1'b0;
						s_d.state             = ACR_ST_IDLE;
						s_d.conversion_result = comparator_out ? (s_q.sar | trial_bit) : s_q.sar;
						s_d.done_flag         = 1'b1;
						s_d.done_pulse        = 1'b1;
					end
				end
			end
			ACR_ST_ABORT: begin
				if (tick && !s_q.restart) begin
					if (s_q.wait_count == ACR_ABORT_PERIODS - 4'd1) begin
						s_d.state = ACR_ST_IDLE;
					end else begin
						s_d.wait_count = s_q.wait_count + 4'd1;
					end
				end
			end
			default: s_d.state = ACR_ST_IDLE;
		endcase

		if (start) begin
			s_d.go         = 1'b1;
			s_d.state      = ACR_ST_STARTUP;
			s_d.wait_count = 4'd0;
		end

		s_d.analog.powered = s_d.converter_enable;
		s_d.analog.ref_ext = s_d.reference_select;
		if (s_d.channel_select <= ACR_CH_EXT_MAX) begin
			s_d.analog.source = ACR_SRC_EXT;
		end else if (s_d.channel_select == ACR_CH_DAC) begin
			s_d.analog.source = ACR_SRC_DAC;
		end else if (s_d.channel_select == ACR_CH_FVR) begin
			s_d.analog.source = ACR_SRC_FVR;
		end else begin
			s_d.analog.source = ACR_SRC_NONE;
		end
		s_d.analog.ext_index = s_d.channel_select[1:0];
		// Sample only when enabled and idle, hold in startup, conversion and abort
		s_d.analog.sample = s_d.converter_enable && (s_d.state == ACR_ST_IDLE);
		s_d.analog.trial  = (s_d.state == ACR_ST_CONVERT) ? (s_d.sar | (10'h200 >> s_d.bit_index)) : 10'h000;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q                         <= '0;
			s_q.state                   <= ACR_ST_IDLE;
			s_q.conversion_clock_select <= ACR_RST_CS;
			s_q.analog.source           <= ACR_SRC_EXT;
			s_q.conversion_result       <= s_q.conversion_result;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata             = s_q.rdata;
	assign analog                = s_q.analog;
	assign conversion_done_flag  = s_q.done_flag;
	assign conversion_done_pulse = s_q.done_pulse;

	a_go_clears_done: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(s_q.done_pulse) |-> !s_q.go && s_q.done_flag && s_q.state == ACR_ST_IDLE)
		else $error("Go not cleared at completion");
	a_go_reads_busy: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_STARTUP || s_q.state == ACR_ST_CONVERT) |-> s_q.go)
		else $error("Go low during conversion");
	a_start_on_write: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_IDLE && s_q.converter_enable && sw_go_set) |=> s_q.go)
		else $error("Write of go did not start");
	a_abort_keeps: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_ABORT) |-> $stable(s_q.conversion_result) && !s_q.done_pulse)
		else $error("Abort changed result");
	a_ctrl1_zero: assert property (@(posedge clock) disable iff (sys_rst)
		$past(reg_rd) && $past(reg_addr) == ACR_OFS_CTRL1 |-> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
		else $error("Control 1 unused bits nonzero");
	a_right_high: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_RESH && s_q.result_justify_select
		|=> reg_rdata == {6'h00, $past(s_q.conversion_result[9:8])})
		else $error("Right justified high byte wrong");
	a_left_low: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_RESL && !s_q.result_justify_select
		|=> reg_rdata == {$past(s_q.conversion_result[1:0]), 6'h00})
		else $error("Left justified low byte wrong");
	a_flag_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.done_pulse |-> s_q.done_flag)
		else $error("Done flag lost");
	a_trigger_start: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_IDLE && s_q.converter_enable && trig_edge && !wr_ctrl0) |=> s_q.go)
		else $error("Trigger did not start");
	a_disabled_idle: assert property (@(posedge clock) disable iff (sys_rst)
		!s_q.converter_enable |-> !s_q.analog.powered || $past(s_q.converter_enable))
		else $error("Powered while disabled");
	a_idle_go_low: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_IDLE || s_q.state == ACR_ST_ABORT) |-> !s_q.go)
		else $error("Go high while not converting");
	a_left_high: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_RESH && !s_q.result_justify_select |=> reg_rdata == $past(s_q.conversion_result[9:2]))
		else $error("Left justified high byte wrong");
	a_right_low: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_RESL && s_q.result_justify_select |=> reg_rdata == $past(s_q.conversion_result[7:0]))
		else $error("Right justified low byte wrong");
	a_ctrl1_field: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_CTRL1 |=> reg_rdata[6:4] == $past(s_q.conversion_clock_select))
		else $error("Clock select readback wrong");
	a_flag_rise_done: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(s_q.done_flag) |-> s_q.done_pulse)
		else $error("Done flag set without completion");
	a_pulse_single: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.done_pulse |=> !s_q.done_pulse)
		else $error("Done pulse longer than one cycle");
	a_pulse_after_convert: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.done_pulse |-> $past(s_q.state) == ACR_ST_CONVERT && $past(tick))
		else $error("Done pulse outside conversion");
	a_result_only_done: assert property (@(posedge clock) disable iff (sys_rst)
		!s_q.done_pulse |-> $stable(s_q.conversion_result))
		else $error("Result changed without completion");
	a_flag_clears: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == ACR_OFS_FLAG && !reg_wdata[ACR_BIT_DONE] |=> !s_q.done_flag || s_q.done_pulse)
		else $error("Done flag not cleared");
	a_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.done_flag && !(reg_wr && reg_addr == ACR_OFS_FLAG && !reg_wdata[ACR_BIT_DONE]) |=> s_q.done_flag)
		else $error("Done flag dropped by itself");
	a_bit_range: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.state == ACR_ST_CONVERT |-> s_q.bit_index < ACR_RESULT_BITS)
		else $error("Bit index out of range");
	a_msb_first: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(s_q.state == ACR_ST_CONVERT) |-> s_q.analog.trial == 10'h200)
		else $error("First trial not most significant bit");
	a_sample_hold: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.state == ACR_ST_CONVERT |-> !s_q.analog.sample)
		else $error("Sampling while resolving");
	a_abort_to_idle: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(s_q.state == ACR_ST_ABORT) |-> s_q.state == ACR_ST_IDLE && !s_q.go)
		else $error("Abort wait left to wrong state");
	a_clear_aborts: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_STARTUP || s_q.state == ACR_ST_CONVERT) && sw_go_clr |=> s_q.state == ACR_ST_ABORT && !s_q.go)
		else $error("Go clear did not abort");
	a_disable_aborts: assert property (@(posedge clock) disable iff (sys_rst)
		(s_q.state == ACR_ST_STARTUP || s_q.state == ACR_ST_CONVERT) && wr_ctrl0 && !reg_wdata[ACR_BIT_EN]
		|=> s_q.state == ACR_ST_ABORT)
		else $error("Disable did not abort");
	a_no_start_disabled: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.state == ACR_ST_IDLE && !s_q.converter_enable |=> s_q.state == ACR_ST_IDLE)
		else $error("Started while disabled");
	a_abort_exits: assert property (@(posedge clock) disable iff (sys_rst)
		s_q.state == ACR_ST_ABORT |=> s_q.state == ACR_ST_ABORT || s_q.state == ACR_ST_IDLE)
		else $error("Start during abort wait");
	a_ref_store: assert property (@(posedge clock) disable iff (sys_rst)
		wr_ctrl0 |=> s_q.analog.ref_ext == $past(reg_wdata[ACR_BIT_REF]))
		else $error("Reference choice not applied");
	a_ext_route: assert property (@(posedge clock) disable iff (sys_rst)
		wr_ctrl0 && reg_wdata[ACR_CHS_HI:ACR_CHS_LO] <= ACR_CH_EXT_MAX
		|=> s_q.analog.source == ACR_SRC_EXT && s_q.analog.ext_index == $past(reg_wdata[ACR_CHS_LO + 1:ACR_CHS_LO]))
		else $error("External input not routed");
	a_dac_route: assert property (@(posedge clock) disable iff (sys_rst)
		wr_ctrl0 && reg_wdata[ACR_CHS_HI:ACR_CHS_LO] == ACR_CH_DAC |=> s_q.analog.source == ACR_SRC_DAC)
		else $error("DAC input not routed");
	a_fvr_route: assert property (@(posedge clock) disable iff (sys_rst)
		wr_ctrl0 && reg_wdata[ACR_CHS_HI:ACR_CHS_LO] == ACR_CH_FVR |=> s_q.analog.source == ACR_SRC_FVR)
		else $error("Fixed reference input not routed");
	a_clock_store: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == ACR_OFS_CTRL1 |=> s_q.conversion_clock_select == $past(reg_wdata[ACR_CS_HI:ACR_CS_LO]))
		else $error("Clock select not stored");
	a_justify_store: assert property (@(posedge clock) disable iff (sys_rst)
		wr_ctrl0 |=> s_q.result_justify_select == $past(reg_wdata[ACR_BIT_JUSTIFY]))
		else $error("Justify bit not stored");
	a_go_readback: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_CTRL0 |=> reg_rdata[ACR_BIT_GO] == $past(s_q.go))
		else $error("Go readback wrong");
	a_flag_readback: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == ACR_OFS_FLAG |=> reg_rdata == {7'h00, $past(s_q.done_flag)})
		else $error("Flag readback wrong");

endmodule

// *** verif/acr_analog_model.sv ***
`timescale 1ns/1ps
module acr_analog_model
	import acr_pkg::*;
(
	// Converter steering
	input  wire acr_pkg::acr_analog_t analog,
	input  wire logic [9:0]           level,
	// Comparator
	output logic                      comparator_out
);
	import acr_pkg::*;
	// Trial compare, high when input at or above
	assign comparator_out = analog.powered ? (level >= analog.trial) : 1'b0;
endmodule

// *** verif/test_adc_control_and_result_regs.sv ***
`timescale 1ns/1ps
module test_adc_control_and_result_regs;
	import acr_pkg::*;
	logic        clock           = 1'b0;
	logic        sys_rst         = 1'b1;
	logic [2:0]  reg_addr        = 3'h0;
	logic [7:0]  reg_wdata       = 8'h00;
	logic        reg_wr          = 1'b0;
	logic        reg_rd          = 1'b0;
	logic [7:0]  reg_rdata;
	logic        special_trigger = 1'b0;
	logic        rc_osc          = 1'b0;
	logic        comparator_out;
	acr_analog_t analog;
	logic        done_flag;
	logic        done_pulse;
	logic [9:0]  level           = 10'h000;
	logic [7:0]  rv;
	int          bad_count       = 0;
	int          check_count     = 0;
	int          pulse_count     = 0;
	localparam int ACQ_CYCLES    = 8;

	acr_core acr_core_i (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.special_trigger, .rc_osc, .comparator_out, .analog,
		.conversion_done_flag(done_flag), .conversion_done_pulse(done_pulse));
	acr_analog_model acr_analog_model_i (.analog, .level, .comparator_out);

	// Counts completion pulses
	always @(posedge clock) begin
		if (done_pulse === 1'b1) begin
			pulse_count <= pulse_count + 1;
		end
	end

	initial begin
		forever #2.5 clock = ~clock;
	end
	// Free running RC source, 8 system cycles a period
	initial begin
		forever #20 rc_osc = ~rc_osc;
	end

	task automatic give_verdict();
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask

	// Polls busy bit, returns elapsed system cycles
	task automatic wait_idle(output int n);
		n = 0;
		do begin
			rd(ACR_OFS_CTRL0);
			n += 2;
			if (n > 4000) begin
				chk("timeout", 0, 1);
				give_verdict();
			end
		end while (rv[ACR_BIT_GO] !== 1'b0);
	endtask

	task automatic t_reset();
		rd(ACR_OFS_CTRL0);
		chk("ctrl0 reset", ACR_RST_CTRL0, rv);
		rd(ACR_OFS_CTRL1);
		chk("ctrl1 reset", 0, rv);
		wr(ACR_OFS_CTRL1, 8'hff);
		rd(ACR_OFS_CTRL1);
		chk("ctrl1 unused", 8'h70, rv);
		rd(3'h5);
		chk("unmapped", 0, rv);
		chk("unpowered", 0, analog.powered);
	endtask

	task automatic t_route();
		logic [3:0] ch [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'he, 4'hf, 4'hf};
		acr_src_t   sr [7] = '{ACR_SRC_EXT, ACR_SRC_EXT, ACR_SRC_EXT, ACR_SRC_EXT,
			ACR_SRC_DAC, ACR_SRC_FVR, ACR_SRC_FVR};
		for (int i = 0; i < 7; i++) begin
			wr(ACR_OFS_CTRL0, {1'b0, i[0], ch[i], 2'b01});
			repeat (2) @(posedge clock);
			chk("source", sr[i], analog.source);
			if (i < 4) chk("index", ch[i][1:0], analog.ext_index);
			chk("reference", i[0], analog.ref_ext);
			chk("powered", 1, analog.powered);
		end
		wr(ACR_OFS_CTRL0, 8'h00);
		repeat (2) @(posedge clock);
		chk("off", 0, analog.powered);
		wr(ACR_OFS_CTRL0, 8'h02);
		rd(ACR_OFS_CTRL0);
		chk("go while off", 0, rv[ACR_BIT_GO]);
	endtask

	task automatic t_conv(input logic [2:0] cs, input int dv, input logic j, input logic [9:0] lv);
		int n;
		int p;
		wr(ACR_OFS_CTRL1, {1'b0, cs, 4'h0});
		level <= lv;
		wr(ACR_OFS_CTRL0, {j, 7'h01});
		repeat (ACQ_CYCLES) @(posedge clock);
		p = pulse_count;
		wr(ACR_OFS_CTRL0, {j, 7'h03});
		rd(ACR_OFS_CTRL0);
		chk("go busy", 1, rv[ACR_BIT_GO]);
		chk("sample hold", 0, analog.sample);
		wait_idle(n);
		chk("duration", 1, n >= 11 * dv - 8 && n <= 11 * dv + 8);
		chk("done pulses", 1, 10'(pulse_count - p));
		chk("flag pin", 1, done_flag);
		chk("sampling", 1, analog.sample);
		rd(ACR_OFS_FLAG);
		chk("done flag", 1, rv[ACR_BIT_DONE]);
		rd(ACR_OFS_RESH);
		chk("result high", j ? {6'h00, lv[9:8]} : lv[9:2], rv);
		rd(ACR_OFS_RESL);
		chk("result low", j ? lv[7:0] : {lv[1:0], 6'h00}, rv);
		wr(ACR_OFS_FLAG, 8'h00);
		rd(ACR_OFS_FLAG);
		chk("flag cleared", 0, rv[ACR_BIT_DONE]);
	endtask

	// Previous result is right justified 1c3
	task automatic t_abort();
		int p;
		wr(ACR_OFS_CTRL1, {1'b0, ACR_CS_DIV64, 4'h0});
		level <= 10'h0aa;
		p = pulse_count;
		wr(ACR_OFS_CTRL0, 8'h83);
		repeat (100) @(posedge clock);
		wr(ACR_OFS_CTRL0, 8'h81);
		rd(ACR_OFS_CTRL0);
		chk("aborted", 0, rv[ACR_BIT_GO]);
		rd(ACR_OFS_RESL);
		chk("kept result", 8'hc3, rv);
		rd(ACR_OFS_FLAG);
		chk("no flag", 0, rv[ACR_BIT_DONE]);
		chk("no pulse", 0, 10'(pulse_count - p));
		wr(ACR_OFS_CTRL0, 8'h83);
		rd(ACR_OFS_CTRL0);
		chk("start in wait", 0, rv[ACR_BIT_GO]);
		repeat (300) @(posedge clock);
		wr(ACR_OFS_CTRL0, 8'h83);
		rd(ACR_OFS_CTRL0);
		chk("restart", 1, rv[ACR_BIT_GO]);
	endtask

	task automatic t_trigger();
		int n;
		wait_idle(n);
		wr(ACR_OFS_FLAG, 8'h00);
		wr(ACR_OFS_CTRL1, 8'h00);
		level <= 10'h155;
		special_trigger <= 1'b1;
		repeat (6) @(posedge clock);
		rd(ACR_OFS_CTRL0);
		chk("trigger go", 1, rv[ACR_BIT_GO]);
		wait_idle(n);
		@(posedge clock);
		special_trigger <= 1'b0;
		rd(ACR_OFS_RESL);
		chk("trigger result", 8'h55, rv);
	endtask

	task automatic t_midreset();
		wr(ACR_OFS_CTRL1, {1'b0, ACR_CS_DIV64, 4'h0});
		wr(ACR_OFS_CTRL0, 8'h83);
		repeat (20) @(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd(ACR_OFS_CTRL0);
		chk("ctrl0 after reset", 0, rv);
		rd(ACR_OFS_CTRL1);
		chk("ctrl1 after reset", 0, rv);
		rd(ACR_OFS_RESH);
		chk("result kept", 8'h55, rv);
		chk("off after reset", 0, analog.powered);
	endtask

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_route();
		t_conv(ACR_CS_DIV2, 2, 1'b0, 10'h3ff);
		t_conv(ACR_CS_DIV4, 4, 1'b1, 10'h000);
		t_conv(ACR_CS_DIV8, 8, 1'b0, 10'h2a5);
		t_conv(ACR_CS_DIV16, 16, 1'b1, 10'h15a);
		t_conv(ACR_CS_DIV32, 32, 1'b0, 10'h301);
		t_conv(ACR_CS_DIV64, 64, 1'b1, 10'h0fe);
		t_conv(ACR_CS_RC, 128, 1'b1, 10'h1c3);
		t_abort();
		t_trigger();
		t_midreset();
		give_verdict();
	end
endmodule
